// ### hdl/packed_right_shift_unit.sv
// What this block does
// - variable halfword arithmetic shift replicates each lane's own sign bit.
// - variable halfword shifts use only amount register bits three to zero.
// - halfword rounding adds one at the top discarded bit per lane.
// - halfword rounding uses seventeen-bit intermediate, returns bits sixteen to one.
// - zero halfword rounding shift appends zero below, result equals input.
// - variable byte shift uses amount register bits two to zero.
// - each byte lane computed independently into its own byte position.
// - byte rounding computes in nine bits, keeps upper eight bits.
// - variable word rounding shift uses amount register bits four to zero.
// - immediate word rounding shift uses shift field, sign fill, rounds.
// - word rounding uses 33-bit intermediate, returns bits 32 to one.
// - immediate halfword logical shift fills zeros, amount zero to fifteen.
// - no exception depends on operand data values.
// - illegal or disabled instruction raises exception instead of result.
`timescale 1ns/1ps

module packed_right_shift_unit
    import rshift_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // request from the pipeline
    input wire logic REQ_VALID_I,
    input wire shift_req_s REQ_I,
    input wire logic MODULE_ENABLE_I,
    // answer to the pipeline
    output logic RSP_VALID_O,
    output shift_rsp_s RSP_O
);

    // =========================================================
    // lane shifters
    // shift helpers: operand with one guard bit below, then shifted (sign fill, or zero fill for the halfword logical op) and incremented when rounding
    function automatic logic [HALF_W-1:0] half_shift(
        input logic [HALF_W-1:0] a, input logic [HALF_AMT_W-1:0] s,
        input logic arith, input logic rnd);
        logic [HALF_W:0] ext;
        logic [HALF_W:0] sh;
        ext = {a, 1'b0};
        sh = arith ? (HALF_W+1)'($signed(ext) >>> s) : (ext >> s);
        if (rnd) begin
            sh = sh + (HALF_W+1)'(1);
        end
        return sh[HALF_W:1];
    endfunction

    function automatic logic [BYTE_W-1:0] byte_shift(
        input logic [BYTE_W-1:0] a, input logic [BYTE_AMT_W-1:0] s, input logic rnd);
        logic [BYTE_W:0] sh;
        sh = (BYTE_W+1)'($signed({a, 1'b0}) >>> s);
        if (rnd) begin
            sh = sh + (BYTE_W+1)'(1);
        end
        return sh[BYTE_W:1];
    endfunction

    function automatic logic [WORD_W-1:0] word_shift(
        input logic [WORD_W-1:0] a, input logic [WORD_AMT_W-1:0] s);
        logic [WORD_W:0] sh;
        sh = (WORD_W+1)'($signed({a, 1'b0}) >>> s);
        sh = sh + (WORD_W+1)'(1);
        return sh[WORD_W:1];
    endfunction

    // =========================================================
    // decode
    logic [HALF_AMT_W-1:0] half_amt;
    logic [BYTE_AMT_W-1:0] byte_amt;
    logic [WORD_AMT_W-1:0] word_amt;
    logic is_half;
    logic is_byte;
    logic half_arith;
    logic half_rnd;
    logic byte_rnd;
    logic legal_op;
    logic [WORD_W-1:0] half_res;
    logic [WORD_W-1:0] byte_res;
    logic [WORD_W-1:0] word_res;
    logic [WORD_W-1:0] result_d;

    always_comb begin
        // immediate halfword ops read only the low four field bits; the top field bit is spare
        half_amt = REQ_I.shift_field_imm[HALF_AMT_W-1:0];
        is_half = 1'b1;
        is_byte = 1'b0;
        half_arith = 1'b1;
        half_rnd = 1'b0;
        byte_rnd = 1'b0;
        legal_op = 1'b1;
        unique case (REQ_I.op)
            OP_HALFWORD_ARITH_SHIFT_IMM: begin
            end
            OP_HALFWORD_ARITH_SHIFT_IMM_ROUND: begin
                half_rnd = 1'b1;
            end
            OP_HALFWORD_ARITH_SHIFT_VAR: begin
                half_amt = REQ_I.amount_source_reg[HALF_AMT_W-1:0];
            end
            OP_HALFWORD_ARITH_SHIFT_VAR_ROUND: begin
                half_amt = REQ_I.amount_source_reg[HALF_AMT_W-1:0];
                half_rnd = 1'b1;
            end
            OP_BYTE_ARITH_SHIFT_VAR: begin
                is_half = 1'b0;
                is_byte = 1'b1;
            end
            OP_BYTE_ARITH_SHIFT_VAR_ROUND: begin
                is_half = 1'b0;
                is_byte = 1'b1;
                byte_rnd = 1'b1;
            end
            OP_WORD_ARITH_SHIFT_VAR_ROUND, OP_WORD_ARITH_SHIFT_IMM_ROUND: begin
                is_half = 1'b0;
            end
            OP_HALFWORD_LOGIC_SHIFT_IMM: begin
                half_arith = 1'b0;
            end
            default: begin
                legal_op = 1'b0;
            end
        endcase
    end

    assign byte_amt = REQ_I.amount_source_reg[BYTE_AMT_W-1:0];

    assign word_amt = (REQ_I.op == OP_WORD_ARITH_SHIFT_VAR_ROUND)
        ? REQ_I.amount_source_reg[WORD_AMT_W-1:0] : REQ_I.shift_field_imm;

    genvar gi;
    generate
        for (gi = 0; gi < HALF_LANES; gi++) begin : g_half
            assign half_res[gi*HALF_W +: HALF_W] = half_shift(
                REQ_I.value_operand_reg[gi*HALF_W +: HALF_W], half_amt, half_arith, half_rnd);
        end
        for (gi = 0; gi < BYTE_LANES; gi++) begin : g_byte
            assign byte_res[gi*BYTE_W +: BYTE_W] = byte_shift(
                REQ_I.value_operand_reg[gi*BYTE_W +: BYTE_W], byte_amt, byte_rnd);
        end
    endgenerate

    assign word_res = word_shift(REQ_I.value_operand_reg, word_amt);

    assign result_d = is_half ? half_res : (is_byte ? byte_res : word_res);

    // =========================================================
    // answer register: one cycle after the request
    // one register stage: the host sees the answer on the edge after it asked
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            RSP_VALID_O <= 1'b0;
        end else begin
            RSP_VALID_O <= REQ_VALID_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            RSP_O <= '0;
        end else if (REQ_VALID_I) begin
            RSP_O.reserved_instr_exc <= !legal_op;
            RSP_O.module_disabled_exc <= legal_op && !MODULE_ENABLE_I;
            // a refused op hands back zero so nothing stale reaches the write-back
            RSP_O.result <= (legal_op && MODULE_ENABLE_I) ? result_d : '0;
        end
    end

    // =========================================================
    // checks
    // exception suppresses result
    AST_EXC_NO_RESULT: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        RSP_VALID_O && (RSP_O.reserved_instr_exc || RSP_O.module_disabled_exc)
        |-> RSP_O.result == '0)
        else $error("exception answer carries a result");
    AST_DISABLED_EXC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && !MODULE_ENABLE_I && legal_op |=> RSP_O.module_disabled_exc)
        else $error("disabled module did not raise exception");
    AST_LATENCY: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I |=> RSP_VALID_O)
        else $error("answer not one cycle after request");
    AST_HALF_ZERO_ROUND: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_HALFWORD_ARITH_SHIFT_VAR_ROUND
        && REQ_I.amount_source_reg[3:0] == 4'h0
        |=> RSP_O.result == $past(REQ_I.value_operand_reg))
        else $error("zero rounding shift changed the value");
    AST_WORD_ZERO_ROUND: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_WORD_ARITH_SHIFT_IMM_ROUND
        && REQ_I.shift_field_imm == 5'h00
        |=> RSP_O.result == $past(REQ_I.value_operand_reg))
        else $error("zero word rounding shift changed the value");
    AST_LOGIC_TOP_ZERO: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_HALFWORD_LOGIC_SHIFT_IMM
        && REQ_I.shift_field_imm[3:0] != 4'h0
        |=> !RSP_O.result[31] && !RSP_O.result[15])
        else $error("logical shift did not zero fill");
    AST_HALF_SIGN: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_HALFWORD_ARITH_SHIFT_VAR
        |=> RSP_O.result[31] == $past(REQ_I.value_operand_reg[31])
        && RSP_O.result[15] == $past(REQ_I.value_operand_reg[15]))
        else $error("halfword sign not kept per lane");
    AST_BYTE_SIGN: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_BYTE_ARITH_SHIFT_VAR
        |=> RSP_O.result[7] == $past(REQ_I.value_operand_reg[7])
        && RSP_O.result[23] == $past(REQ_I.value_operand_reg[23]))
        else $error("byte lane sign not kept");
    AST_HALF_IMM_SIGN: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_HALFWORD_ARITH_SHIFT_IMM
        |=> RSP_O.result[31] == $past(REQ_I.value_operand_reg[31])
        && RSP_O.result[15] == $past(REQ_I.value_operand_reg[15]))
        else $error("immediate halfword sign not kept per lane");

    // answers only follow requests, and a bubble leaves the last answer in place
    AST_RESET_QUIET: assert property (@(posedge CLK_I)
        SYS_RST_I |=> !RSP_VALID_O && RSP_O == '0)
        else $error("answer not cleared by reset");
    AST_NO_SPURIOUS: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !REQ_VALID_I |=> !RSP_VALID_O)
        else $error("answer without a request");
    AST_HOLD: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !REQ_VALID_I |=> $stable(RSP_O))
        else $error("answer changed without a request");
    AST_EXC_EXCLUSIVE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        RSP_VALID_O |-> !(RSP_O.reserved_instr_exc && RSP_O.module_disabled_exc))
        else $error("both exceptions raised together");
    AST_ILLEGAL_EXC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && REQ_I.op > OP_HALFWORD_LOGIC_SHIFT_IMM
        |=> RSP_O.reserved_instr_exc && !RSP_O.module_disabled_exc && RSP_O.result == '0)
        else $error("unknown operation not refused");
    AST_DISABLED_REFUSE: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && !MODULE_ENABLE_I && REQ_I.op <= OP_HALFWORD_LOGIC_SHIFT_IMM
        |=> RSP_O.module_disabled_exc && !RSP_O.reserved_instr_exc && RSP_O.result == '0)
        else $error("disabled operation still produced a result");
    AST_LEGAL_NO_EXC: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op <= OP_HALFWORD_LOGIC_SHIFT_IMM
        |=> !RSP_O.reserved_instr_exc && !RSP_O.module_disabled_exc)
        else $error("legal operation raised an exception");

    // zero amounts must hand the operand back untouched in every lane
    AST_HALF_IMM_ZERO: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_HALFWORD_ARITH_SHIFT_IMM_ROUND
        && REQ_I.shift_field_imm[HALF_AMT_W-1:0] == '0
        |=> RSP_O.result == $past(REQ_I.value_operand_reg))
        else $error("zero immediate rounding shift changed the value");
    AST_BYTE_ZERO_ROUND: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_BYTE_ARITH_SHIFT_VAR_ROUND
        && REQ_I.amount_source_reg[BYTE_AMT_W-1:0] == '0
        |=> RSP_O.result == $past(REQ_I.value_operand_reg))
        else $error("zero byte rounding shift changed the value");
    AST_WORD_VAR_ZERO: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_WORD_ARITH_SHIFT_VAR_ROUND
        && REQ_I.amount_source_reg[WORD_AMT_W-1:0] == '0
        |=> RSP_O.result == $past(REQ_I.value_operand_reg))
        else $error("zero word variable shift changed the value");
    AST_LOGIC_ZERO: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_HALFWORD_LOGIC_SHIFT_IMM
        && REQ_I.shift_field_imm[HALF_AMT_W-1:0] == '0
        |=> RSP_O.result == $past(REQ_I.value_operand_reg))
        else $error("zero logical shift changed the value");

    // the widest shift leaves only copies of each lane's sign, or zeros above the lane's top bit moved to bit zero
    AST_HALF_FULL_SHIFT: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_HALFWORD_ARITH_SHIFT_VAR
        && REQ_I.amount_source_reg[HALF_AMT_W-1:0] == '1
        |=> RSP_O.result == {{HALF_W{$past(REQ_I.value_operand_reg[WORD_W-1])}},
            {HALF_W{$past(REQ_I.value_operand_reg[HALF_W-1])}}})
        else $error("full halfword shift did not keep only the sign");
    AST_BYTE_FULL_SHIFT: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_BYTE_ARITH_SHIFT_VAR
        && REQ_I.amount_source_reg[BYTE_AMT_W-1:0] == '1
        |=> RSP_O.result == {{BYTE_W{$past(REQ_I.value_operand_reg[31])}},
            {BYTE_W{$past(REQ_I.value_operand_reg[23])}},
            {BYTE_W{$past(REQ_I.value_operand_reg[15])}},
            {BYTE_W{$past(REQ_I.value_operand_reg[7])}}})
        else $error("full byte shift did not keep only the sign");
    AST_LOGIC_FULL_SHIFT: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        REQ_VALID_I && MODULE_ENABLE_I && REQ_I.op == OP_HALFWORD_LOGIC_SHIFT_IMM
        && REQ_I.shift_field_imm[HALF_AMT_W-1:0] == '1
        |=> RSP_O.result == {{(HALF_W-1){1'b0}}, $past(REQ_I.value_operand_reg[WORD_W-1]),
            {(HALF_W-1){1'b0}}, $past(REQ_I.value_operand_reg[HALF_W-1])})
        else $error("full logical shift did not leave only the top bit");

    // =========================================================
    // scenario covers
    COV_HALF_ROUND: cover property (@(posedge CLK_I)
        REQ_VALID_I && REQ_I.op == OP_HALFWORD_ARITH_SHIFT_VAR_ROUND);
    COV_BYTE_ROUND: cover property (@(posedge CLK_I)
        REQ_VALID_I && REQ_I.op == OP_BYTE_ARITH_SHIFT_VAR_ROUND);
    COV_WORD_ROUND: cover property (@(posedge CLK_I)
        REQ_VALID_I && REQ_I.op == OP_WORD_ARITH_SHIFT_VAR_ROUND);
    COV_ILLEGAL: cover property (@(posedge CLK_I) RSP_VALID_O && RSP_O.reserved_instr_exc);
    COV_DISABLED: cover property (@(posedge CLK_I)
        RSP_VALID_O && RSP_O.module_disabled_exc);

endmodule // packed_right_shift_unit

// ### hdl/rshift_pkg.sv
package rshift_pkg;

    // =========================================================
    // operation selection
    typedef enum logic [3:0] {
        OP_HALFWORD_ARITH_SHIFT_IMM       = 4'h0,
        OP_HALFWORD_ARITH_SHIFT_IMM_ROUND = 4'h1,
        OP_HALFWORD_ARITH_SHIFT_VAR       = 4'h2,
        OP_HALFWORD_ARITH_SHIFT_VAR_ROUND = 4'h3,
        OP_BYTE_ARITH_SHIFT_VAR           = 4'h4,
        OP_BYTE_ARITH_SHIFT_VAR_ROUND     = 4'h5,
        OP_WORD_ARITH_SHIFT_VAR_ROUND     = 4'h6,
        OP_WORD_ARITH_SHIFT_IMM_ROUND     = 4'h7,
        OP_HALFWORD_LOGIC_SHIFT_IMM       = 4'h8
    } shift_op_e;

    // =========================================================
    // widths and lane layout
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int HALF_LANES = 2;
    localparam int BYTE_LANES = 4;
    localparam int HALF_AMT_W = 4;
    localparam int BYTE_AMT_W = 3;
    localparam int WORD_AMT_W = 5;

    // =========================================================
    // request and answer carriers
    typedef struct packed {
        shift_op_e op;
        logic [WORD_W-1:0] value_operand_reg;
        logic [WORD_W-1:0] amount_source_reg;
        logic [WORD_AMT_W-1:0] shift_field_imm;
    } shift_req_s;

    typedef struct packed {
        logic [WORD_W-1:0] result;
        logic reserved_instr_exc;
        logic module_disabled_exc;
    } shift_rsp_s;

endpackage

// ### testbench/host_pipe_model.sv
`timescale 1ns/1ps

module host_pipe_model
    import rshift_pkg::*;
(
    // pipeline clock
    input wire logic clk_i,
    // request side
    output logic req_valid_o,
    output shift_req_s req_o,
    output logic enable_o,
    // answer side
    input wire logic rsp_valid_i,
    input wire shift_rsp_s rsp_i
);
    shift_rsp_s wb_q;

    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
        enable_o = 1'b1;
    end

    // ==========================================
    // issue and write-back
    // decoded op with operands
    task automatic issue(input shift_req_s r, input logic en);
        @(posedge clk_i);
        #1;
        req_valid_o = 1'b1;
        req_o = r;
        enable_o = en;
    endtask

    // pipeline bubble; operands scrambled so stale values are never trusted
    task automatic idle();
        @(posedge clk_i);
        #1;
        req_valid_o = 1'b0;
        req_o = ~req_o;
    endtask

    always @(negedge clk_i) begin
        if (rsp_valid_i === 1'b1) begin
            wb_q <= rsp_i;
        end
    end
endmodule // host_pipe_model

// ### testbench/tb_packed_right_shift_unit.sv
`timescale 1ns/1ps

module tb_packed_right_shift_unit;
    import rshift_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid, enable, rsp_valid;
    shift_req_s req;
    shift_rsp_s rsp;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int qc[$];
    logic [33:0] qe[$];
    logic [31:0] st = 32'h2b89;
    logic [33:0] last_exp = 34'h0;

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    packed_right_shift_unit packed_right_shift_unit_inst (.CLK_I(clk), .SYS_RST_I(rst),
        .REQ_VALID_I(req_valid), .REQ_I(req), .MODULE_ENABLE_I(enable),
        .RSP_VALID_O(rsp_valid), .RSP_O(rsp));
    host_pipe_model host_pipe_model_inst (.clk_i(clk), .req_valid_o(req_valid), .req_o(req),
        .enable_o(enable), .rsp_valid_i(rsp_valid), .rsp_i(rsp));

    // ==========================================
    // reference model
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic longint lane(longint x, int w, int s, bit ar, bit rn);
        longint m;
        m = (longint'(1) << w) - 1;
        x = x & m;
        if (ar && x[w-1]) x = x - (m + 1);
        if (rn) x = (((x <<< 1) >>> s) + 1) >>> 1;
        else x = x >>> s;
        return x & m;
    endfunction

    function automatic logic [33:0] ref_rsp(shift_req_s r, logic en);
        int op, w, s;
        logic [31:0] res;
        op = r.op;
        res = '0;
        if (op > 8) return {32'h0, 2'b10};
        if (!en) return {32'h0, 2'b01};
        w = (op == 4 || op == 5) ? 8 : (op == 6 || op == 7) ? 32 : 16;
        s = (op inside {2, 3, 4, 5, 6}) ? int'(r.amount_source_reg & (w - 1))
                                          : int'(r.shift_field_imm) & (w - 1);
        for (int k = 0; k < 32 / w; k++)
            res = res | 32'(lane(longint'(r.value_operand_reg >> (k * w)), w, s,
                  op != 8, op inside {1, 3, 5, 6, 7}) << (k * w));
        return {res, 2'b00};
    endfunction

    // ==========================================
    // checking
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(negedge clk) begin
        if (!rst && rsp_valid !== 1'b0) begin
            if (qe.size() == 0) check(34'h1, 34'h0);
            else begin
                check(34'(cyc), 34'(qc.pop_front()));
                check(rsp, qe.pop_front());
            end
        end
    end

    task automatic send(input shift_req_s r, input logic en);
        host_pipe_model_inst.issue(r, en);
        qc.push_back(cyc + 1);
        qe.push_back(ref_rsp(r, en));
        last_exp = qe[$];
    endtask

    // ==========================================
    // stimulus
    initial begin
        shift_req_s r;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check(34'(rsp_valid), 34'h0);
        check(rsp, 34'h0);
        #3 rst = 1'b0;
        // boundary amounts with high amount bits set, every op code
        for (int op = 0; op < 16; op++) begin
            for (int j = 0; j < 2; j++) begin
                r = {4'(op), 32'h8001_7f81, j ? 32'hffff_ffff : 32'hffff_ffe0, j ? 5'h1f : 5'h0};
                send(r, 1'b1);
            end
        end
        repeat (400) begin
            st = lfsr_next(st);
            r.value_operand_reg = st;
            st = lfsr_next(st);
            r.amount_source_reg = st;
            r.op = shift_op_e'(st[7:4]);
            r.shift_field_imm = st[12:8];
            send(r, st[15:13] != 3'h0 || st[7:4] > 4'h8);
            if (st[16]) host_pipe_model_inst.idle();
        end
        host_pipe_model_inst.idle();
        repeat (3) @(posedge clk);
        check(34'(qe.size()), 34'h0);
        check(host_pipe_model_inst.wb_q, last_exp);
        wrap_up();
    end

    initial begin
        #(4 * 5000);
        n_mismatch++;
        wrap_up();
    end
endmodule // tb_packed_right_shift_unit
